// file: shared/loop_torque_regs.svh
`ifndef LOOP_TORQUE_REGS_SVH
`define LOOP_TORQUE_REGS_SVH

// Register word offsets on the plain register port.
`define REG_CTRL        4'h0
`define REG_DEST        4'h1
`define REG_AMPS_LIM    4'h2
`define REG_QAMPS_LIM   4'h3
`define REG_TORQ_CONST  4'h4
`define REG_CMD         4'h5
`define REG_STATUS      4'h6
`define REG_IRQ_STAT    4'h7
`define REG_IRQ_CLR     4'h8
`define REG_IRQ_EN      4'h9
`define REG_LOOP_ERR    4'ha
`define REG_CUR_SET     4'hb
`define REG_GAINS       4'hc

// Control register field positions.
`define CTRL_SENS_LO    0
`define CTRL_MODE_LO    2
`define CTRL_BLDC_BIT   4
`define CTRL_PROT_BIT   5
`define CTRL_EXTS_BIT   6
// Control reset value: current protection on, supervision off, open loop.
`define CTRL_RESET      7'h20

// Command register: kind in bits 18 to 16, value in the low sixteen.
`define CMD_KIND_LO     16

// Loop error thresholds in counts and persistence times in ms.
`define ERR_LIM_1       32'sd100
`define ERR_LIM_2       32'sd250
`define ERR_LIM_3       32'sd500
`define ERR_MS_1        250
`define ERR_MS_2        500
`define ERR_MS_3        1000

// Generic command full scale.
`define CMD_FULL        32'sd1000
// Torque unit is hundredths of Nm, direct current unit tenths of an amp.
`define TORQ_DIV        32'sd100
// Setpoints are in mA, so one tenth of an amp is a hundred of them.
`define MA_PER_TENTH    32'sd100

// Clock rate and cycles per millisecond.
`define CLK_HZ          40000000
`define CYC_PER_MS      (`CLK_HZ / 1000)

// Interrupt bit positions.
`define IRQ_DEST        0
`define IRQ_FAULT       1
`define IRQ_CURERR      2

`endif

// file: shared/loop_torque_pkg.sv
package loop_torque_pkg;

    typedef enum logic [1:0] {
        MODE_OPEN = 2'h0,
        MODE_POSITION = 2'h1,
        MODE_TORQUE = 2'h2
    } op_mode_e;

    typedef enum logic [2:0] {
        CMD_GENERIC = 3'h0,
        CMD_TORQUE_NM = 3'h1,
        CMD_QUAD = 3'h2,
        CMD_FLUX = 3'h3,
        CMD_DEST = 3'h4
    } cmd_kind_e;

    typedef enum logic [2:0] {
        LOOP_RUN = 3'b001,
        LOOP_STOPPED = 3'b010,
        LOOP_OPEN = 3'b100
    } loop_state_e;

    // Register port request from software.
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Current setpoints toward the power stage.
    typedef struct packed {
        logic signed [15:0] quad_ma;
        logic signed [15:0] flux_ma;
    } cur_set_s;

endpackage

// file: hdl/loop_error_torque_command.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "loop_torque_regs.svh"

// What this block does
// - Flag destination reached when trajectory equals commanded destination.
// - Loop error is desired minus actual position, judged by size and time.
// - Setting one faults after error above 100 for 250 ms.
// - Setting two faults after error above 250 for 500 ms.
// - Setting three faults after error above 500 for 1000 ms.
// - Fault stops channel until it clears, then channel drops to open loop.
// - New absolute destination command clears an active fault.
// - Torque mode regulates current to the command whatever the speed.
// - Generic command spans -1000..1000, scaled so full scale is amps limit.
// - Brushless sinusoidal scales generic command against quadrature limit.
// - Torque command in hundredths Nm converts to current by torque constant.
// - Brushless sinusoidal accepts direct quadrature current in tenths amp.
// - Brushless sinusoidal accepts direct flux current in tenths amp.
// - Torque mode feeds back measured motor current, same loop structure.
// - In torque mode, persistent large current error removes power by default, can be disabled.
// - Brushless torque mode limits speed with separate speed gains.
// - Estimated current reads zero while output power level is zero.
// - External sensor input maps onto full command range as feedback.
module loop_error_torque_command #(
    parameter int MS_CYCLES = `CYC_PER_MS,
    parameter int CUR_ERR_MS = `ERR_MS_2
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic signed [31:0] traj_pos_i,
    input wire logic signed [31:0] actual_pos_i,
    input wire logic signed [15:0] motor_ma_i,
    input wire logic signed [15:0] ext_sensor_i,
    input wire logic [6:0] power_level_i,
    input wire logic current_estimated_i,
    input wire logic signed [15:0] speed_i,
    input wire logic signed [15:0] speed_limit_i,
    output logic dest_reached_o,
    output logic loop_fault_o,
    output logic channel_stop_o,
    output logic closed_loop_o,
    output logic power_off_o,
    output logic speed_limit_o,
    output logic signed [15:0] quad_set_o,
    output logic signed [15:0] flux_set_o,
    output logic signed [15:0] cur_fb_o,
    output logic irq_o
);

    // A zero length window would trip a fault on the first noisy sample.
    // Refused at elaboration so a bad build never reaches the motor.
    if (MS_CYCLES < 1 || CUR_ERR_MS < 1) begin : g_bad_timing
        $error("Timing parameters must be at least one.");
    end

    loop_torque_pkg::reg_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // Register state.
    logic [6:0] ctrl_r, ctrl_nxt;
    logic signed [31:0] dest_r, dest_nxt;
    logic [15:0] amps_lim_r, amps_lim_nxt, qamps_lim_r, qamps_lim_nxt, tconst_r, tconst_nxt;
    logic [2:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt;
    logic [31:0] gains_r, gains_nxt, rdata_r, rdata_nxt;
    logic dest_cmd_pulse;
    loop_torque_pkg::cur_set_s set_r, set_nxt;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // Loop state.
    loop_torque_pkg::loop_state_e st_r, st_nxt;
    logic [31:0] persist_r, persist_nxt, cur_tmr_r, cur_tmr_nxt;
    logic signed [31:0] err, err_mag, err_lim;
    logic [31:0] err_cycles;
    logic dest_r1, dest_hit, fault_now, cur_fault;
    logic signed [31:0] cur_err;

    logic [1:0] sens;
    logic [1:0] mode;
    assign sens = ctrl_r[`CTRL_SENS_LO +: 2];
    assign mode = ctrl_r[`CTRL_MODE_LO +: 2];

    // loop error
    // The subtraction is kept at 32 bits; extreme positions can wrap.
    always_comb begin
        err = traj_pos_i - actual_pos_i;
        err_mag = err[31] ? -err : err;
    end

    // Threshold and persistence pair selected by the sensitivity setting.
    always_comb begin
        case (sens)
            2'h1: begin
                err_lim = `ERR_LIM_1;
                err_cycles = 32'(`ERR_MS_1 * MS_CYCLES);
            end
            2'h2: begin
                err_lim = `ERR_LIM_2;
                err_cycles = 32'(`ERR_MS_2 * MS_CYCLES);
            end
            2'h3: begin
                err_lim = `ERR_LIM_3;
                err_cycles = 32'(`ERR_MS_3 * MS_CYCLES);
            end
            default: begin
                err_lim = 32'sh7fffffff;
                err_cycles = 32'hffffffff;
            end
        endcase
    end

    assign dest_hit = (traj_pos_i == dest_r);

    // Only closed loop position or torque tracking is supervised.
    // timer restart
    always_comb begin
        persist_nxt = 32'h0;
        if (st_r == loop_torque_pkg::LOOP_RUN && mode != 2'(loop_torque_pkg::MODE_OPEN)
            && sens != 2'h0 && err_mag > err_lim) begin
            persist_nxt = (persist_r >= err_cycles) ? persist_r : persist_r + 32'h1;
        end
        // A new destination restarts the window from zero.
        if (dest_cmd_pulse) persist_nxt = 32'h0;
    end
    assign fault_now = (persist_r >= err_cycles) && (sens != 2'h0);

    // Fault sequencing: stop, then open loop once the error is gone.
    // stop then open
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            loop_torque_pkg::LOOP_RUN: if (fault_now) st_nxt = loop_torque_pkg::LOOP_STOPPED;
            loop_torque_pkg::LOOP_STOPPED: begin
                if (dest_cmd_pulse) st_nxt = loop_torque_pkg::LOOP_RUN;
                else if (err_mag <= err_lim) st_nxt = loop_torque_pkg::LOOP_OPEN;
            end
            loop_torque_pkg::LOOP_OPEN: if (dest_cmd_pulse) st_nxt = loop_torque_pkg::LOOP_RUN;
            default: st_nxt = loop_torque_pkg::LOOP_RUN;
        endcase
    end

    logic signed [15:0] fb_nxt, fb_r;
    always_comb begin
        if (ctrl_r[`CTRL_EXTS_BIT]) fb_nxt = ext_sensor_i;
        else if (current_estimated_i && power_level_i == 7'h0) fb_nxt = 16'sh0;
        else fb_nxt = motor_ma_i;
    end

    // current protection
    // The timer only advances in torque mode; disabling protection is advised there.
    always_comb begin
        cur_err = 32'(set_r.quad_ma) - 32'(fb_r);
        if (cur_err < 0) cur_err = -cur_err;
        cur_tmr_nxt = 32'h0;
        if (ctrl_r[`CTRL_PROT_BIT] && mode == 2'(loop_torque_pkg::MODE_TORQUE)
            && cur_err > 32'(amps_lim_r) / 2) begin
            cur_tmr_nxt = (cur_tmr_r >= 32'(CUR_ERR_MS * MS_CYCLES)) ? cur_tmr_r
                                                                      : cur_tmr_r + 32'h1;
        end
    end
    assign cur_fault = cur_tmr_r >= 32'(CUR_ERR_MS * MS_CYCLES);

    // Register writes, command scaling and sticky interrupt bits.
    logic signed [31:0] cmd_val, scaled;
    logic [2:0] cmd_kind;
    logic [2:0] irq_ev;
    always_comb begin
        ctrl_nxt = ctrl_r;
        dest_nxt = dest_r;
        amps_lim_nxt = amps_lim_r;
        qamps_lim_nxt = qamps_lim_r;
        tconst_nxt = tconst_r;
        irq_en_nxt = irq_en_r;
        gains_nxt = gains_r;
        set_nxt = set_r;
        dest_cmd_pulse = 1'b0;
        cmd_val = 32'(signed'(req.wdata[15:0]));
        cmd_kind = req.wdata[`CMD_KIND_LO +: 3];
        scaled = 32'sh0;
        if (req.wr) begin
            if (hit(req.addr, `REG_CTRL)) ctrl_nxt = req.wdata[6:0];
            if (hit(req.addr, `REG_AMPS_LIM)) amps_lim_nxt = req.wdata[15:0];
            if (hit(req.addr, `REG_QAMPS_LIM)) qamps_lim_nxt = req.wdata[15:0];
            if (hit(req.addr, `REG_TORQ_CONST)) tconst_nxt = req.wdata[15:0];
            if (hit(req.addr, `REG_IRQ_EN)) irq_en_nxt = req.wdata[2:0];
            if (hit(req.addr, `REG_GAINS)) gains_nxt = req.wdata;
            if (hit(req.addr, `REG_DEST)) begin
                dest_nxt = req.wdata;
                dest_cmd_pulse = 1'b1;
            end
            if (hit(req.addr, `REG_CMD)) begin
                case (cmd_kind)
                    3'(loop_torque_pkg::CMD_GENERIC): begin
                        if (cmd_val > `CMD_FULL) cmd_val = `CMD_FULL;
                        if (cmd_val < -`CMD_FULL) cmd_val = -`CMD_FULL;
                        // Limits are widened as signed so negative commands stay negative.
                        scaled = (cmd_val * (ctrl_r[`CTRL_BLDC_BIT] ? $signed(32'(qamps_lim_r))
                                  : $signed(32'(amps_lim_r)))) / `CMD_FULL;
                        set_nxt.quad_ma = scaled[15:0];
                    end
                    3'(loop_torque_pkg::CMD_TORQUE_NM): begin
                        scaled = (cmd_val * $signed(32'(tconst_r))) / `TORQ_DIV;
                        set_nxt.quad_ma = scaled[15:0];
                    end
                    3'(loop_torque_pkg::CMD_QUAD):
                        if (ctrl_r[`CTRL_BLDC_BIT]) begin
                            scaled = cmd_val * `MA_PER_TENTH;
                            set_nxt.quad_ma = scaled[15:0];
                        end
                    3'(loop_torque_pkg::CMD_FLUX):
                        if (ctrl_r[`CTRL_BLDC_BIT]) begin
                            scaled = cmd_val * `MA_PER_TENTH;
                            set_nxt.flux_ma = scaled[15:0];
                        end
                    default: set_nxt = set_r;
                endcase
            end
        end
        irq_ev = 3'h0;
        irq_ev[`IRQ_DEST] = dest_hit & ~dest_r1;
        irq_ev[`IRQ_FAULT] = fault_now & (st_r == loop_torque_pkg::LOOP_RUN);
        irq_ev[`IRQ_CURERR] = cur_fault;
        // A new event wins over a clear in the same cycle.
        irq_stat_nxt = irq_stat_r;
        if (req.wr && hit(req.addr, `REG_IRQ_CLR)) irq_stat_nxt = irq_stat_r & ~req.wdata[2:0];
        irq_stat_nxt = irq_stat_nxt | irq_ev;
        rdata_nxt = 32'h0;
        if (req.rd) begin
            case (req.addr)
                `REG_CTRL: rdata_nxt = {25'h0, ctrl_r};
                `REG_DEST: rdata_nxt = dest_r;
                `REG_AMPS_LIM: rdata_nxt = {16'h0, amps_lim_r};
                `REG_QAMPS_LIM: rdata_nxt = {16'h0, qamps_lim_r};
                `REG_TORQ_CONST: rdata_nxt = {16'h0, tconst_r};
                `REG_STATUS: rdata_nxt = {26'h0, cur_fault, speed_limit_o, st_r, dest_hit};
                `REG_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
                `REG_IRQ_EN: rdata_nxt = {29'h0, irq_en_r};
                `REG_LOOP_ERR: rdata_nxt = err;
                `REG_CUR_SET: rdata_nxt = set_r;
                `REG_GAINS: rdata_nxt = gains_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // speed limiting
    // Speed gains sit in the low half of the gain word, current gains above.
    logic spd_lim_nxt;
    always_comb begin
        spd_lim_nxt = ctrl_r[`CTRL_BLDC_BIT] && mode == 2'(loop_torque_pkg::MODE_TORQUE)
                      && gains_r[15:0] != 16'h0
                      && ((speed_i > speed_limit_i) || (speed_i < -speed_limit_i));
    end

    // All state registers.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= `CTRL_RESET;
            dest_r <= 32'sh0;
            amps_lim_r <= 16'h0;
            qamps_lim_r <= 16'h0;
            tconst_r <= 16'h0;
            irq_stat_r <= 3'h0;
            irq_en_r <= 3'h0;
            gains_r <= 32'h0;
            rdata_r <= 32'h0;
            set_r <= '0;
            st_r <= loop_torque_pkg::LOOP_RUN;
            persist_r <= 32'h0;
            cur_tmr_r <= 32'h0;
            // Trajectory and destination both reset to zero, so the flag starts set.
            // Starting the edge detector high avoids a false event after reset.
            dest_r1 <= 1'b1;
            fb_r <= 16'sh0;
            speed_limit_o <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            dest_r <= dest_nxt;
            amps_lim_r <= amps_lim_nxt;
            qamps_lim_r <= qamps_lim_nxt;
            tconst_r <= tconst_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            gains_r <= gains_nxt;
            rdata_r <= rdata_nxt;
            set_r <= set_nxt;
            st_r <= st_nxt;
            persist_r <= persist_nxt;
            cur_tmr_r <= cur_tmr_nxt;
            dest_r1 <= dest_hit;
            fb_r <= fb_nxt;
            speed_limit_o <= spd_lim_nxt;
        end
    end

    // Output flops.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0;
            dest_reached_o <= 1'b0;
            loop_fault_o <= 1'b0;
            channel_stop_o <= 1'b0;
            closed_loop_o <= 1'b0;
            power_off_o <= 1'b0;
            quad_set_o <= 16'sh0;
            flux_set_o <= 16'sh0;
            cur_fb_o <= 16'sh0;
            irq_o <= 1'b0;
        end else begin
            reg_rdata_o <= rdata_nxt;
            dest_reached_o <= dest_hit;
            loop_fault_o <= st_nxt == loop_torque_pkg::LOOP_STOPPED;
            channel_stop_o <= st_nxt == loop_torque_pkg::LOOP_STOPPED;
            closed_loop_o <= st_nxt == loop_torque_pkg::LOOP_RUN
                             && mode != 2'(loop_torque_pkg::MODE_OPEN);
            power_off_o <= cur_fault;
            quad_set_o <= set_nxt.quad_ma;
            flux_set_o <= set_nxt.flux_ma;
            cur_fb_o <= fb_nxt;
            irq_o <= |(irq_stat_nxt & irq_en_nxt);
        end
    end

    sens_one_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (sens == 2'h1 && st_r == loop_torque_pkg::LOOP_RUN && persist_r >= err_cycles)
        |=> st_r == loop_torque_pkg::LOOP_STOPPED) else $error("Fault not taken.");
    timer_restart_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (err_mag <= err_lim) |=> persist_r == 32'h0) else $error("Timer not restarted.");
    dest_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (dest_cmd_pulse && st_r != loop_torque_pkg::LOOP_RUN)
        |=> st_r == loop_torque_pkg::LOOP_RUN) else $error("Fault not cleared.");
    stop_open_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_r == loop_torque_pkg::LOOP_STOPPED && !dest_cmd_pulse && err_mag <= err_lim)
        |=> st_r == loop_torque_pkg::LOOP_OPEN ##1 !closed_loop_o) else $error("No open loop.");
    dest_flag_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (traj_pos_i == dest_r) |=> dest_reached_o) else $error("Destination flag missing.");
    zero_est_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (current_estimated_i && power_level_i == 7'h0 && !ctrl_r[`CTRL_EXTS_BIT])
        |=> cur_fb_o == 16'sh0) else $error("Estimate not zero.");
    quad_direct_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (req.wr && req.addr == `REG_CMD && ctrl_r[`CTRL_BLDC_BIT]
         && req.wdata[`CMD_KIND_LO +: 3] == 3'(loop_torque_pkg::CMD_QUAD))
        |=> quad_set_o == 16'($past(cmd_val) * `MA_PER_TENTH)) else $error("Quad setpoint wrong.");
    cur_prot_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !ctrl_r[`CTRL_PROT_BIT] |=> !cur_fault) else $error("Protection active when off.");

endmodule // loop_error_torque_command

// file: tb/power_stage_model.sv
module power_stage_model #(
    parameter int STEP = 4000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic follow_i,
    input wire logic signed [15:0] set_i,
    output logic signed [15:0] ma_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // An unloaded motor draws no current; a loaded one slews toward the setpoint.
    // The slew limit keeps the bench from seeing an unrealistically instant loop.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ma_o <= 16'sh0000;
        end else if (!follow_i) begin
            ma_o <= 16'sh0000;
        end else if (int'(set_i) - int'(ma_o) > STEP) begin
            ma_o <= ma_o + 16'(STEP);
        end else if (int'(ma_o) - int'(set_i) > STEP) begin
            ma_o <= ma_o - 16'(STEP);
        end else begin
            ma_o <= set_i;
        end
    end
endmodule // power_stage_model

// file: tb/tb.sv
`include "loop_torque_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MS = 4;
    typedef struct packed {logic [3:0] sel; logic [31:0] val;} note_s;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, cur_est = 1'b0, follow = 1'b0;
    logic [31:0] reg_rdata_o;
    logic signed [31:0] traj = 32'sh0, actual = 32'sh0;
    logic signed [15:0] motor_ma, speed = 16'sh0, spd_lim = 16'sh7fff, ext = 16'sh0;
    logic [6:0] power = 7'h32;
    logic dest_o, fault_o, stop_o, closed_o, pwr_off_o, spd_o, irq_o;
    logic signed [15:0] quad_o, flux_o, fb_o;
    logic rd_seen = 1'b0, look_r = 1'b0;
    note_s q[$];
    note_s n;
    int err_count = 0, tests_run = 0, cyc = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    loop_error_torque_command #(.MS_CYCLES(MS)) DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .traj_pos_i(traj),
        .actual_pos_i(actual), .motor_ma_i(motor_ma), .ext_sensor_i(ext),
        .power_level_i(power), .current_estimated_i(cur_est), .speed_i(speed),
        .speed_limit_i(spd_lim), .dest_reached_o(dest_o), .loop_fault_o(fault_o),
        .channel_stop_o(stop_o), .closed_loop_o(closed_o), .power_off_o(pwr_off_o),
        .speed_limit_o(spd_o), .quad_set_o(quad_o), .flux_set_o(flux_o), .cur_fb_o(fb_o),
        .irq_o(irq_o));

    power_stage_model #(.STEP(4000)) stage (.clk_i(ref_clk_i), .nrst_i(nrst_i),
        .follow_i(follow), .set_i(quad_o), .ma_o(motor_ma));

    // Selector: 0 read data, 1 dest, 2 fault, 3 stop, 4 closed, 5 power off,
    // 6 speed limit, 7 quad, 8 flux, 9 feedback, 10 interrupt.
    function automatic logic [31:0] pick(logic [3:0] s);
        case (s)
            4'h0: return reg_rdata_o;
            4'h1: return {31'h0, dest_o};
            4'h2: return {31'h0, fault_o};
            4'h3: return {31'h0, stop_o};
            4'h4: return {31'h0, closed_o};
            4'h5: return {31'h0, pwr_off_o};
            4'h6: return {31'h0, spd_o};
            4'h7: return 32'(quad_o);
            4'h8: return 32'(flux_o);
            4'h9: return 32'(fb_o);
            default: return {31'h0, irq_o};
        endcase
    endfunction

    function automatic logic [31:0] cmd(int k, int v);
        return {13'h0, 3'(k), 16'(v)};
    endfunction

    // Monitor takes the oldest note whenever read data or a sampled output is due.
    always @(posedge ref_clk_i) begin
        rd_seen <= reg_rd_i;
        if (rd_seen || look_r) begin
            n = q.pop_front();
            tests_run++;
            if (pick(n.sel) !== n.val) begin
                err_count++;
                $display("MISMATCH at %0t: sel %0d got %h want %h", $time, n.sel, pick(n.sel),
                    n.val);
            end
        end
    end

    // A hang is cut off well beyond the longest persistence sequence.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            $display("MISMATCH at %0t: run did not finish", $time);
            conclude();
        end
    end

    task automatic step(int k);
        repeat (k) @(posedge ref_clk_i);
    endtask

    // Strobes drop after one edge and one idle edge follows, so no task re-raises at once.
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rd(logic [3:0] a, logic [31:0] v);
        q.push_back('{4'h0, v});
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic look(logic [3:0] s, logic [31:0] v);
        q.push_back('{s, v});
        look_r <= 1'b1;
        @(posedge ref_clk_i);
        look_r <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // Drive a loop error at, then past, the threshold of one sensitivity setting.
    task automatic trip(logic [1:0] s, int lim, int ms, int sg);
        wr(`REG_CTRL, 32'h4 | 32'(s));
        traj <= 32'sh0;
        actual <= 32'sh0;
        wr(`REG_DEST, 32'h0);
        look(4'h4, 32'h1); // running closed loop
        traj <= sg * lim;
        step(ms * MS + 5);
        look(4'h2, 32'h0); // error at threshold never trips
        traj <= sg * (lim + 1);
        step(ms * MS - 10);
        traj <= sg * lim;
        step(1);
        traj <= sg * (lim + 1);
        step(ms * MS - 4);
        look(4'h2, 32'h0); // timer restarted by one quiet cycle
        step(6);
        look(4'h2, 32'h1); // fault raised
        look(4'h3, 32'h1); // channel stopped
        look(4'h4, 32'h0); // loop opened
        rd(`REG_STATUS, 32'h4); // stopped state reported
        rd(`REG_LOOP_ERR, 32'(sg * (lim + 1))); // desired minus actual
        traj <= 32'sh0;
        step(2);
        look(4'h3, 32'h0); // stop lifted
        look(4'h4, 32'h0); // left in open loop
        wr(`REG_DEST, 32'h0);
        look(4'h2, 32'h0); // fault cleared
        look(4'h4, 32'h1); // closed loop again
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence: reset, registers, supervision, then current commands.
    initial begin
        int v;
        int seed;
        seed = $urandom(21);
        step(10);
        nrst_i <= 1'b1;
        step(1);
        rd(`REG_CTRL, 32'h20); // protection on by default
        rd(4'hf, 32'h0);
        wr(`REG_CTRL, 32'h4);
        wr(`REG_DEST, 32'd1234);
        traj <= 32'sd1234;
        actual <= -32'sd5;
        step(2);
        look(4'h1, 32'h1); // flag follows trajectory not motor
        traj <= 32'sd1233;
        step(2);
        look(4'h1, 32'h0); // flag drops off destination
        wr(`REG_IRQ_EN, 32'h2);
        trip(2'h1, 100, 250, 1); // setting one
        look(4'ha, 32'h1);
        wr(`REG_IRQ_EN, 32'h0);
        look(4'ha, 32'h0);
        wr(`REG_IRQ_EN, 32'h2);
        look(4'ha, 32'h1);
        wr(`REG_IRQ_CLR, 32'h2);
        look(4'ha, 32'h0);
        trip(2'h2, 250, 500, -1); // setting two, negative error
        trip(2'h3, 500, 1000, 1); // setting three
        wr(`REG_CTRL, 32'h8);
        wr(`REG_AMPS_LIM, 32'd20000);
        wr(`REG_QAMPS_LIM, 32'd10000);
        wr(`REG_TORQ_CONST, 32'd1000);
        // Full scale both ways, then random commands inside the legal span.
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 1000 : (i == 1) ? -1000 : int'($urandom_range(2000)) - 1000;
            wr(`REG_CMD, cmd(0, v));
            look(4'h7, 32'(v * 20)); // scaled by amps limit
        end
        wr(`REG_CMD, cmd(1, 250));
        look(4'h7, 32'd2500); // torque constant applied
        wr(`REG_CMD, cmd(1, -300));
        look(4'h7, 32'(-3000)); // negative torque
        wr(`REG_CMD, cmd(2, 50));
        look(4'h7, 32'(-3000)); // ignored when brushed
        wr(`REG_CMD, cmd(3, 5));
        look(4'h8, 32'h0); // ignored when brushed
        wr(`REG_CTRL, 32'h18);
        wr(`REG_CMD, cmd(0, 1000));
        look(4'h7, 32'd10000); // quadrature limit
        wr(`REG_CMD, cmd(0, -500));
        look(4'h7, 32'(-5000)); // half scale
        wr(`REG_CMD, cmd(2, 123));
        look(4'h7, 32'd12300); // tenths of an amp
        wr(`REG_CMD, cmd(3, -45));
        look(4'h8, 32'(-4500)); // tenths of an amp
        follow <= 1'b1;
        speed <= 16'sh7000;
        step(10);
        look(4'h9, 32'd12300); // measured current fed back at any speed
        cur_est <= 1'b1;
        power <= 7'h00;
        step(2);
        look(4'h9, 32'h0); // estimate blank at zero power
        power <= 7'h32;
        step(2);
        look(4'h9, 32'd12300); // estimate back with power
        ext <= 16'sd777;
        wr(`REG_CTRL, 32'h58);
        look(4'h9, 32'd777); // external sensor fed back
        wr(`REG_CTRL, 32'h18);
        wr(`REG_GAINS, 32'h0001_0001);
        speed <= 16'sd900;
        spd_lim <= 16'sd800;
        step(2);
        look(4'h6, 32'h1); // overspeed limited
        speed <= 16'sd700;
        step(2);
        look(4'h6, 32'h0); // under the limit
        follow <= 1'b0;
        wr(`REG_CTRL, 32'h38);
        wr(`REG_CMD, cmd(2, 200));
        step(500 * MS - 8);
        look(4'h5, 32'h0); // not yet tripped
        step(12);
        look(4'h5, 32'h1); // power removed
        conclude();
    end
endmodule // tb
